// [mcs_dec_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface mcs_dec_if;
   logic       valid;
   logic       left;
   logic       sgn;
   logic       pair;
   logic       eight;
   logic       by_reg;
   logic [2:0] tgt;
   logic [2:0] amt_reg;
   logic [3:0] imm;
   modport dec (output valid, left, sgn, pair, eight, by_reg, tgt, amt_reg, imm);
   modport core (input valid, left, sgn, pair, eight, by_reg, tgt, amt_reg, imm);
endinterface
`default_nettype wire

// [mcs_decoder.sv]
`timescale 1ns/1ps
`default_nettype none
module mcs_decoder
   import mcs_pkg::*;
(
   input  wire logic [15:0] instr_i,
   mcs_dec_if.dec           dec
);
   // ------------------------------------------------------------
   // prefix matches
   // ------------------------------------------------------------
   wire pw_sfx  = (instr_i[2:0] == SFX_PW);
   wire m_pwr   = (instr_i[15:6] == PFX_PW_RIGHT_REG) && pw_sfx;
   wire m_pwri  = (instr_i[15:7] == PFX_PW_RIGHT_IMM) && pw_sfx;
   wire m_l8    = (instr_i[15:3] == PFX_LEFT_EIGHT);
   wire m_r8    = (instr_i[15:3] == PFX_RIGHT_EIGHT);
   wire m_l     = (instr_i[15:6] == PFX_LEFT_REG);
   wire m_li    = (instr_i[15:7] == PFX_LEFT_IMM);
   wire m_ls    = (instr_i[15:6] == PFX_LEFT_S_REG);
   wire m_lsi   = (instr_i[15:7] == PFX_LEFT_S_IMM);
   wire m_r     = (instr_i[15:6] == PFX_RIGHT_REG);
   wire m_ri    = (instr_i[15:7] == PFX_RIGHT_IMM);
   wire m_rs    = (instr_i[15:6] == PFX_RIGHT_S_REG);

   assign dec.valid   = m_pwr | m_pwri | m_l8 | m_r8 | m_l | m_li | m_ls | m_lsi
                      | m_r | m_ri | m_rs;
   assign dec.pair    = m_pwr | m_pwri;
   assign dec.eight   = m_l8 | m_r8;
   assign dec.left    = m_l8 | m_l | m_li | m_ls | m_lsi;
   assign dec.sgn     = m_ls | m_lsi | m_rs;
   assign dec.by_reg  = m_pwr | m_l | m_ls | m_r | m_rs;
   assign dec.tgt     = instr_i[TGT_LSB +: RSEL_W];
   assign dec.amt_reg = instr_i[AMT_LSB +: RSEL_W];
   assign dec.imm     = instr_i[IMM_LSB +: IMM_W];
endmodule
`default_nettype wire

// [mcs_pkg.sv]
package mcs_pkg;
   // ------------------------------------------------------------
   // widths
   // ------------------------------------------------------------
   localparam int unsigned WORD_W     = 16;
   localparam int unsigned PAIR_W     = 32;
   localparam int unsigned NREG       = 8;
   localparam int unsigned RSEL_W     = 3;
   localparam int unsigned CNT_W      = 16;
   localparam int unsigned FIXED_SH   = 8;
   // ------------------------------------------------------------
   // instruction fields
   // ------------------------------------------------------------
   localparam int unsigned TGT_LSB    = 0;
   localparam int unsigned AMT_LSB    = 3;
   localparam int unsigned IMM_LSB    = 3;
   localparam int unsigned IMM_W      = 4;
   localparam int unsigned PW_IMM_LSB = 3;
   // prefixes, bit 15 first
   localparam logic [9:0]  PFX_PW_RIGHT_REG  = 10'h0E4; // 0011100100
   localparam logic [8:0]  PFX_PW_RIGHT_IMM  = 9'h070;  // 001110000
   localparam logic [2:0]  SFX_PW            = 3'h5;    // 101
   localparam logic [9:0]  PFX_LEFT_REG      = 10'h0BA; // 0010111010
   localparam logic [12:0] PFX_LEFT_EIGHT    = 13'h05DF;// 0010111011111
   localparam logic [8:0]  PFX_LEFT_IMM      = 9'h05A;  // 001011010
   localparam logic [9:0]  PFX_LEFT_S_REG    = 10'h0B8; // 0010111000
   localparam logic [8:0]  PFX_LEFT_S_IMM    = 9'h058;  // 001011000
   localparam logic [9:0]  PFX_RIGHT_REG     = 10'h0B9; // 0010111001
   localparam logic [12:0] PFX_RIGHT_EIGHT   = 13'h05DE;// 0010111011110
   localparam logic [8:0]  PFX_RIGHT_IMM     = 9'h059;  // 001011001
   localparam logic [9:0]  PFX_RIGHT_S_REG   = 10'h0B7; // 0010110111
   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [WORD_W-1:0] REG_RST = 16'h0000;
endpackage

// [mcs_seq_model.sv]
`timescale 1ns/1ps
`default_nettype none
module mcs_seq_model (
   input  wire logic        clock_i,
   output logic             issue_o,
   output logic [15:0]      instr_o,
   output logic             wr_en_o,
   output logic [2:0]       wr_sel_o,
   output logic [15:0]      wr_data_o,
   output logic             pair_wr_o,
   output logic [15:0]      hi_o,
   output logic [15:0]      lo_o
);
   logic        go_i, go_w, go_p;
   logic [15:0] nxt_instr, nxt_data, nxt_hi, nxt_lo;
   logic [2:0]  nxt_sel;
   initial begin
      {go_i, go_w, go_p, issue_o, wr_en_o, pair_wr_o} = 6'h00;
      {instr_o, wr_data_o, hi_o, lo_o, wr_sel_o} = 67'h0;
   end
   // idle lines invert so a stale value never passes for a fresh one
   always @(negedge clock_i) begin
      issue_o   <= go_i;
      instr_o   <= go_i ? nxt_instr : ~instr_o;
      wr_en_o   <= go_w;
      wr_sel_o  <= go_w ? nxt_sel : ~wr_sel_o;
      wr_data_o <= go_w ? nxt_data : ~wr_data_o;
      pair_wr_o <= go_p;
      hi_o      <= go_p ? nxt_hi : ~hi_o;
      lo_o      <= go_p ? nxt_lo : ~lo_o;
      {go_i, go_w, go_p} = 3'h0;
   end
   // step past the driving edge so the next call never overwrites a pending request
   task automatic send(input logic [15:0] w);
      nxt_instr = w;
      go_i = 1'b1;
      @(negedge clock_i);
      #1;
   endtask
   task automatic wr(input logic [2:0] s, input logic [15:0] d);
      {nxt_sel, nxt_data, go_w} = {s, d, 1'b1};
      @(negedge clock_i);
      #1;
   endtask
   task automatic pair(input logic [15:0] h, input logic [15:0] l);
      {nxt_hi, nxt_lo, go_p} = {h, l, 1'b1};
      @(negedge clock_i);
      #1;
   endtask
endmodule
`default_nettype wire

// [mcs_shift_props.sv]
`timescale 1ns/1ps
`default_nettype none
module mcs_shift_props
   import mcs_pkg::*;
(
   input  wire logic         clock_i,
   input  wire logic         rstn_i,
   input  wire logic         issue_i,
   input  wire logic [15:0]  instr_i,
   input  wire logic         wr_en_i,
   input  wire logic         busy_o,
   input  wire logic         done_o,
   input  wire logic         illegal_o,
   input  wire logic [127:0] arith_regs_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rstn_i);
   logic [2:0] tgt_ff;
   logic       sgn_ff;
   logic       spend_ff;
   wire logic        take     = issue_i && !busy_o;
   wire logic [15:0] tgt_word = arith_regs_o[{instr_i[2:0], 4'h0} +: 16];
   wire logic [15:0] cur_word = arith_regs_o[{tgt_ff, 4'h0} +: 16];
   wire logic        is_l8    = instr_i[15:3] == PFX_LEFT_EIGHT;
   wire logic        is_r8    = instr_i[15:3] == PFX_RIGHT_EIGHT;
   wire logic        is_sgn   = instr_i[15:6] == PFX_LEFT_S_REG || instr_i[15:6] == PFX_RIGHT_S_REG
                                || instr_i[15:7] == PFX_LEFT_S_IMM;
   wire logic        is_pwi   = instr_i[15:7] == PFX_PW_RIGHT_IMM && instr_i[2:0] == SFX_PW;
   wire logic        is_imm   = instr_i[15:7] == PFX_LEFT_IMM || instr_i[15:7] == PFX_RIGHT_IMM
                                || instr_i[15:7] == PFX_LEFT_S_IMM || is_pwi;
   // target index captured on every take; sign bit only checked while a signed shift is pending
   always_ff @(posedge clock_i) begin
      if (take) begin
         tgt_ff <= instr_i[2:0];
         sgn_ff <= tgt_word[15];
      end
      if (!rstn_i) spend_ff <= 1'b0;
      else if (take && is_sgn) spend_ff <= 1'b1;
      else if (done_o) spend_ff <= 1'b0;
   end
   sequence three_steps;
      busy_o [*3] ##1 (done_o && !busy_o);
   endsequence
   a_left_eight_val: assert property (take && is_l8 && !wr_en_i |=> done_o && !busy_o
      && cur_word == ($past(tgt_word) << 8)) else $error("left by eight wrong");
   a_right_eight_val: assert property (take && is_r8 && !wr_en_i |=> done_o && !busy_o
      && cur_word == ($past(tgt_word) >> 8)) else $error("right by eight wrong");
   a_imm_three_steps: assert property (take && is_imm && instr_i[6:3] == 4'h3 |=> three_steps)
      else $error("literal three shift timing wrong");
   a_imm_zero_amt: assert property (take && is_imm && instr_i[6:3] == 4'h0 |=> done_o && !busy_o)
      else $error("zero literal shift not immediate");
   a_sign_bit_kept: assert property (spend_ff |-> cur_word[15] == sgn_ff)
      else $error("sign bit changed in signed shift");
   a_busy_end_done: assert property ($fell(busy_o) |-> done_o)
      else $error("busy ended without done");
   a_busy_quiet_out: assert property (busy_o |-> !done_o && !illegal_o)
      else $error("done or illegal while busy");
   a_illegal_word: assert property (take && instr_i == 16'h0000 |=> illegal_o && !done_o && !busy_o)
      else $error("unknown word not flagged");
endmodule
`default_nettype wire

// [mcs_shift_unit.sv]
// Operation
// - product halves form one 32-bit word
// - pair right shift by register amount
// - immediate amount from 4-bit field
// - one cycle per shifted position
// - left-by-eight done in one cycle
// - right-by-eight done in one cycle
// - two-register shift writes back first operand
// - immediate shift writes back target register
// - signed shifts keep sign bit
// - left shifts set shift-out and overflow
// - right shifts set shift-out and precision-loss
// - operands are 3-bit arithmetic register fields
// - decode product-word right shift encodings
// - decode left shift prefixes
// - decode right shift prefixes
`timescale 1ns/1ps
`default_nettype none
module mcs_shift_unit
   import mcs_pkg::*;
(
   input  wire logic                        clock_i,
   input  wire logic                        rstn_i,
   input  wire logic                        issue_i,
   input  wire logic [15:0]                 instr_i,
   input  wire logic                        wr_en_i,
   input  wire logic [mcs_pkg::RSEL_W-1:0]  wr_sel_i,
   input  wire logic [mcs_pkg::WORD_W-1:0]  wr_data_i,
   input  wire logic                        pair_wr_i,
   input  wire logic [mcs_pkg::WORD_W-1:0]  product_high_half_i,
   input  wire logic [mcs_pkg::WORD_W-1:0]  product_low_half_i,
   output logic                             busy_o,
   output logic                             done_o,
   output logic                             illegal_o,
   output logic [mcs_pkg::NREG*mcs_pkg::WORD_W-1:0] arith_regs_o,
   output logic [mcs_pkg::WORD_W-1:0]       product_high_half_o,
   output logic [mcs_pkg::WORD_W-1:0]       product_low_half_o,
   output logic                             shifted_out_flag_o,
   output logic                             shift_overflow_flag_o,
   output logic                             precision_loss_flag_o
);
   import mcs_pkg::*;

   typedef enum logic [0:0] {
      MCS_IDLE = 1'b0,
      MCS_RUN  = 1'b1
   } mcs_state_e;

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic [WORD_W-1:0] arith_reg_subset_ff [NREG];
   logic [PAIR_W-1:0] product_pair_word_ff;
   mcs_state_e        state_ff;
   logic [CNT_W-1:0]  cnt_ff;
   logic              left_ff;
   logic              sgn_ff;
   logic              pair_ff;
   logic [2:0]        tgt_ff;
   logic              busy_ff;
   logic              done_ff;
   logic              illegal_ff;
   logic              sb_ff;
   logic              mo_ff;
   logic              ml_ff;

   mcs_dec_if dif();

   mcs_decoder u_dec (
      .instr_i (instr_i),
      .dec     (dif.dec)
   );

   // ------------------------------------------------------------
   // issue decode
   // ------------------------------------------------------------
   wire               take      = issue_i && (state_ff == MCS_IDLE);
   wire               take_ok   = take && dif.valid;
   wire [WORD_W-1:0]  amt_reg_v = arith_reg_subset_ff[dif.amt_reg];
   // amount register value taken whole: a large value just means many cycles
   wire [CNT_W-1:0]   amt_v     = dif.by_reg ? amt_reg_v
                                             : {{(CNT_W-IMM_W){1'b0}}, dif.imm};
   wire [WORD_W-1:0]  tgt_v     = arith_reg_subset_ff[dif.tgt];

   // fixed eight-position results, single cycle
   wire [WORD_W-1:0]  l8_res    = {tgt_v[WORD_W-1-FIXED_SH:0], {FIXED_SH{1'b0}}};
   wire [WORD_W-1:0]  r8_res    = {{FIXED_SH{1'b0}}, tgt_v[WORD_W-1:FIXED_SH]};
   wire               l8_sb     = tgt_v[WORD_W-FIXED_SH];
   wire               l8_mo     = |tgt_v[WORD_W-1:WORD_W-FIXED_SH];
   wire               r8_sb     = tgt_v[FIXED_SH-1];
   wire               r8_ml     = |tgt_v[FIXED_SH-1:0];

   // ------------------------------------------------------------
   // one-position step
   // ------------------------------------------------------------
   wire [WORD_W-1:0]  cur_r     = arith_reg_subset_ff[tgt_ff];
   wire               sign_b    = cur_r[WORD_W-1];
   wire [WORD_W-1:0]  step_l    = sgn_ff ? {sign_b, cur_r[WORD_W-3:0], 1'b0}
                                         : {cur_r[WORD_W-2:0], 1'b0};
   wire [WORD_W-1:0]  step_r    = sgn_ff ? {sign_b, sign_b, cur_r[WORD_W-2:1]}
                                         : {1'b0, cur_r[WORD_W-1:1]};
   wire               out_l     = sgn_ff ? cur_r[WORD_W-2] : cur_r[WORD_W-1];
   wire               out_r     = cur_r[0];
   // signed left overflows when the bit lost differs from the sign
   wire               ovf_l     = sgn_ff ? (cur_r[WORD_W-2] != sign_b) : cur_r[WORD_W-1];
   wire [PAIR_W-1:0]  step_p    = {1'b0, product_pair_word_ff[PAIR_W-1:1]};
   wire               out_p     = product_pair_word_ff[0];
   wire               last      = (cnt_ff == {{(CNT_W-1){1'b0}}, 1'b1});
   wire               run       = (state_ff == MCS_RUN);

   // ------------------------------------------------------------
   // sequencer
   // ------------------------------------------------------------
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         state_ff   <= MCS_IDLE;
         cnt_ff     <= '0;
         left_ff    <= 1'b0;
         sgn_ff     <= 1'b0;
         pair_ff    <= 1'b0;
         tgt_ff     <= 3'h0;
         busy_ff    <= 1'b0;
         done_ff    <= 1'b0;
         illegal_ff <= 1'b0;
      end else begin
         done_ff    <= 1'b0;
         illegal_ff <= take && !dif.valid;
         if (take_ok) begin
            left_ff <= dif.left;
            sgn_ff  <= dif.sgn;
            pair_ff <= dif.pair;
            tgt_ff  <= dif.tgt;
            cnt_ff  <= amt_v;
            if (dif.eight || amt_v == '0) begin
               done_ff <= 1'b1;
            end else begin
               state_ff <= MCS_RUN;
               busy_ff  <= 1'b1;
            end
         end else if (run) begin
            cnt_ff <= cnt_ff - 1'b1;
            if (last) begin
               state_ff <= MCS_IDLE;
               busy_ff  <= 1'b0;
               done_ff  <= 1'b1;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // register file and product word
   // ------------------------------------------------------------
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         for (int i = 0; i < NREG; i++) begin
            arith_reg_subset_ff[i] <= REG_RST;
         end
         product_pair_word_ff <= {REG_RST, REG_RST};
      end else begin
         // sequencer writes are blocked while a shift runs
         if (wr_en_i && !run) begin
            arith_reg_subset_ff[wr_sel_i] <= wr_data_i;
         end
         if (pair_wr_i && !run) begin
            product_pair_word_ff <= {product_high_half_i, product_low_half_i};
         end
         if (take_ok && dif.eight) begin
            arith_reg_subset_ff[dif.tgt] <= dif.left ? l8_res : r8_res;
         end
         if (run) begin
            if (pair_ff) begin
               product_pair_word_ff <= step_p;
            end else begin
               arith_reg_subset_ff[tgt_ff] <= left_ff ? step_l : step_r;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // condition flags
   // ------------------------------------------------------------
   // flags restart when a decodable issue is taken; overflow and precision-loss gather across every step, shift-out keeps the last bit
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         sb_ff <= 1'b0;
         mo_ff <= 1'b0;
         ml_ff <= 1'b0;
      end else if (take_ok) begin
         sb_ff <= dif.eight ? (dif.left ? l8_sb : r8_sb) : 1'b0;
         mo_ff <= dif.eight && dif.left && l8_mo;
         ml_ff <= dif.eight && !dif.left && r8_ml;
      end else if (run) begin
         if (pair_ff) begin
            sb_ff <= out_p;
            ml_ff <= ml_ff | out_p;
         end else if (left_ff) begin
            sb_ff <= out_l;
            mo_ff <= mo_ff | ovf_l;
         end else begin
            sb_ff <= out_r;
            ml_ff <= ml_ff | out_r;
         end
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   always_comb begin
      for (int i = 0; i < NREG; i++) begin
         arith_regs_o[i*WORD_W +: WORD_W] = arith_reg_subset_ff[i];
      end
   end

   assign busy_o                = busy_ff;
   assign done_o                = done_ff;
   assign illegal_o             = illegal_ff;
   assign product_high_half_o   = product_pair_word_ff[PAIR_W-1:WORD_W];
   assign product_low_half_o    = product_pair_word_ff[WORD_W-1:0];
   assign shifted_out_flag_o    = sb_ff;
   assign shift_overflow_flag_o = mo_ff;
   assign precision_loss_flag_o = ml_ff;
endmodule
`default_nettype wire

// [testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import mcs_pkg::*;
   logic clock_i = 1'b0;
   logic rstn_i  = 1'b0;
   wire logic         issue_i, wr_en_i, pair_wr_i, busy_o, done_o, illegal_o, sb, mo, ml;
   wire logic [15:0]  instr_i, wr_data_i, hi_i, lo_i, hi_o, lo_o;
   wire logic [2:0]   wr_sel_i;
   wire logic [127:0] regs_o;
   int fails = 0;
   int n_checks = 0;
   int cyc = 0;
   always #25 clock_i = ~clock_i;
   mcs_seq_model i_seq (.clock_i(clock_i), .issue_o(issue_i), .instr_o(instr_i), .wr_en_o(wr_en_i),
      .wr_sel_o(wr_sel_i), .wr_data_o(wr_data_i), .pair_wr_o(pair_wr_i), .hi_o(hi_i), .lo_o(lo_i));
   mcs_shift_unit i_dut (.clock_i(clock_i), .rstn_i(rstn_i), .issue_i(issue_i), .instr_i(instr_i),
      .wr_en_i(wr_en_i), .wr_sel_i(wr_sel_i), .wr_data_i(wr_data_i), .pair_wr_i(pair_wr_i),
      .product_high_half_i(hi_i), .product_low_half_i(lo_i), .busy_o(busy_o), .done_o(done_o),
      .illegal_o(illegal_o), .arith_regs_o(regs_o), .product_high_half_o(hi_o),
      .product_low_half_o(lo_o), .shifted_out_flag_o(sb), .shift_overflow_flag_o(mo),
      .precision_loss_flag_o(ml));
   // ---------------------------------------------------------------
   // checking helpers
   // ---------------------------------------------------------------
   task automatic chk_val(input logic [127:0] got, input logic [127:0] exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_cyc(input int got, input int exp);
      n_checks++;
      if (got != exp) begin
         fails++;
         $display("MISMATCH t=%0t cycles got=%h exp=%h", $time, got, exp);
      end
   endtask
   function automatic logic [15:0] rg(input int i);
      return regs_o[i*16 +: 16];
   endfunction
   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // edges from the taking edge until done is seen
   task automatic run(input logic [15:0] w, input int n);
      int c;
      c = 0;
      i_seq.send(w);
      do begin
         @(posedge clock_i);
         #1;
         c++;
      end while (done_o !== 1'b1 && c < 40);
      chk_cyc(c, n);
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_eight();
      i_seq.wr(3'd1, 16'h12F4);
      run({PFX_LEFT_EIGHT, 3'd1}, 1);
      chk_val({rg(1), sb, mo}, {16'hF400, 2'b01});
      run({PFX_RIGHT_EIGHT, 3'd1}, 1);
      chk_val({rg(1), sb, ml}, {16'h00F4, 2'b00});
      i_seq.wr(3'd1, 16'h12F4);
      run({PFX_RIGHT_EIGHT, 3'd1}, 1);
      chk_val({rg(1), sb, ml}, {16'h0012, 2'b11});
      $display("eight-position shifts done");
   endtask
   task automatic t_reg();
      i_seq.wr(3'd2, 16'h8001);
      i_seq.wr(3'd3, 16'h0002);
      run({PFX_LEFT_REG, 3'd3, 3'd2}, 3);
      chk_val({rg(2), rg(3), sb, mo}, {16'h0004, 16'h0002, 2'b01});
      i_seq.wr(3'd2, 16'h0006);
      run({PFX_RIGHT_REG, 3'd3, 3'd2}, 3);
      chk_val({rg(2), sb, ml}, {16'h0001, 2'b11});
      $display("register-amount shifts done");
   endtask
   task automatic t_signed();
      i_seq.wr(3'd4, 16'h8018);
      i_seq.wr(3'd5, 16'h0004);
      run({PFX_RIGHT_S_REG, 3'd5, 3'd4}, 5);
      chk_val({rg(4), sb, ml}, {16'hF801, 2'b11});
      i_seq.wr(3'd6, 16'h4001);
      run({PFX_LEFT_S_IMM, 4'h3, 3'd6}, 4);
      chk_val({rg(6), sb, mo}, {16'h0008, 2'b01});
      run({PFX_RIGHT_IMM, 4'h0, 3'd6}, 1);
      run({PFX_LEFT_IMM, 4'h1, 3'd6}, 2);
      chk_val({rg(6), sb, mo}, {16'h0010, 2'b00});
      $display("signed and literal shifts done");
   endtask
   task automatic t_pair();
      i_seq.pair(16'h0003, 16'h0003);
      i_seq.wr(3'd7, 16'h0001);
      run({PFX_PW_RIGHT_IMM, 4'h2, SFX_PW}, 3);
      chk_val({hi_o, lo_o, sb, ml}, {32'h0000C000, 2'b11});
      run({PFX_PW_RIGHT_REG, 3'd7, SFX_PW}, 2);
      chk_val({hi_o, lo_o, sb, ml}, {32'h00006000, 2'b00});
      $display("product word shifts done");
   endtask
   task automatic t_refuse();
      i_seq.send(16'h0000);
      @(posedge clock_i);
      #1;
      chk_val({illegal_o, done_o, busy_o}, 3'b100);
      i_seq.send({PFX_LEFT_IMM, 4'h3, 3'd6});
      i_seq.send({PFX_LEFT_EIGHT, 3'd6});
      i_seq.wr(3'd6, 16'hFFFF);
      repeat (4) @(posedge clock_i);
      #1;
      chk_val(rg(6), 16'h0080);
      $display("refusal cases done");
   endtask
   always @(posedge clock_i) begin
      cyc++;
      if (cyc == 2000) begin
         fails++;
         test_done();
      end
   end
   initial begin
      repeat (5) @(negedge clock_i);
      rstn_i = 1'b1;
      @(posedge clock_i);
      #1;
      chk_val(regs_o, 128'h0);
      chk_val({hi_o, lo_o, busy_o, done_o, illegal_o, sb, mo, ml}, 38'h0);
      t_eight();
      t_reg();
      t_signed();
      t_pair();
      t_refuse();
      test_done();
   end
endmodule
bind mcs_shift_unit mcs_shift_props i_props (.clock_i(clock_i), .rstn_i(rstn_i),
   .issue_i(issue_i), .instr_i(instr_i), .wr_en_i(wr_en_i), .busy_o(busy_o), .done_o(done_o),
   .illegal_o(illegal_o), .arith_regs_o(arith_regs_o));
`default_nettype wire
